/* File: gpc_cfg_mem.sv */
// Per-pin configuration store with a registered read port
`timescale 1ns/1ps
module gpc_cfg_mem (
    input  wire logic       clk_sys,                 // System clock
    input  wire logic       rst,                     // Async reset
    input  wire logic [5:0] waddr,                   // Write pin index
    input  wire logic [7:0] wdata,                   // Write data
    input  wire logic       we,                      // Write enable
    input  wire logic [5:0] raddr,                   // Read pin index
    output logic      [7:0] rdata,                   // Registered read
    output logic [gpc_pkg::NUM_PINS*8-1:0] all_cfg   // Every pin config
);
    logic [7:0] mem_r   [gpc_pkg::NUM_PINS];
    logic [7:0] mem_nxt [gpc_pkg::NUM_PINS];
    logic [7:0] rdata_nxt;

    // Pins 16..31 belong to ports 2 and 3
    function automatic logic [7:0] rst_val(input int i);
        return ((i / 8) == 2 || (i / 8) == 3) ? gpc_pkg::RST_CFG_PLAIN
                                               : gpc_pkg::RST_CFG_EVT;
    endfunction

    always_comb begin
        for (int i = 0; i < gpc_pkg::NUM_PINS; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (we && waddr < 6'(gpc_pkg::NUM_PINS)) begin
            mem_nxt[waddr] = wdata;
        end
        rdata_nxt = (raddr < 6'(gpc_pkg::NUM_PINS)) ? mem_r[raddr] : 8'h00;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < gpc_pkg::NUM_PINS; i++) begin
                mem_r[i] <= rst_val(i);
            end
            rdata <= 8'h00;
        end else begin
            for (int i = 0; i < gpc_pkg::NUM_PINS; i++) begin
                mem_r[i] <= mem_nxt[i];
            end
            rdata <= rdata_nxt;
        end
    end

    always_comb begin
        for (int i = 0; i < gpc_pkg::NUM_PINS; i++) begin
            all_cfg[i*8 +: 8] = mem_r[i];
        end
    end
endmodule

/* File: gpc_pin_env.sv */
// Board side of the pins: resolves each pad from all drivers
`timescale 1ns/1ps
module gpc_pin_env (
    input wire logic        clk_sys,    // Clock
    input wire logic [39:0] pin_out,    // Design value
    input wire logic [39:0] pin_oe_n,   // Design enable, low drives
    input wire logic [39:0] pin_pullup, // Pull-up on
    input wire logic [39:0] ext_drv,    // Board value
    input wire logic [39:0] ext_en,     // Board drives
    output logic     [39:0] pin_in      // Pad levels
);
    logic [39:0] flt_r = 40'h0;
    // Floating pads wander, so nothing may rely on them
    always @(posedge clk_sys) flt_r <= ~flt_r;
    always_comb begin
        for (int i = 0; i < 40; i++) begin
            if (ext_en[i])
                pin_in[i] = ext_drv[i];
            else if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else
                pin_in[i] = pin_pullup[i] | flt_r[i];
        end
    end
endmodule

/* File: gpc_pkg.sv */
// Package: constants and carrier types of the GPIO configuration block
package gpc_pkg;

    // ------------------------------------------------------------
    // Configuration register indexes
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_UNIT_ACTIVATE  = 8'h30;
    localparam logic [7:0] IDX_BASE_HIGH      = 8'h60;
    localparam logic [7:0] IDX_BASE_LOW       = 8'h61;
    localparam logic [7:0] IDX_IRQ_NUMBER     = 8'h70;
    localparam logic [7:0] IDX_IRQ_TYPE       = 8'h71;
    localparam logic [7:0] IDX_DMA_REPORT_A   = 8'h74;
    localparam logic [7:0] IDX_DMA_REPORT_B   = 8'h75;
    localparam logic [7:0] IDX_PIN_SELECTOR   = 8'hF0;
    localparam logic [7:0] IDX_PIN_CONFIG_WIN = 8'hF1;
    localparam logic [7:0] IDX_RUN_BASE       = 8'h80;
    localparam logic [7:0] IDX_EVT_STATUS     = 8'hE0;
    localparam logic [7:0] IDX_EVT_MASK       = 8'hE1;
    localparam logic [3:0] RUN_SPAN           = 4'hF;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ACTIVATE  = 8'h00;
    localparam logic [7:0] RST_BASE      = 8'h00;
    localparam logic [7:0] RST_IRQ_NUM   = 8'h00;
    localparam logic [7:0] RST_IRQ_TYPE  = 8'h03;
    localparam logic [7:0] VAL_NO_DMA    = 8'h04;
    localparam logic [7:0] RST_SELECTOR  = 8'h00;
    localparam logic [7:0] RST_CFG_EVT   = 8'h44;
    localparam logic [7:0] RST_CFG_PLAIN = 8'h04;
    localparam logic [7:0] RST_DATA      = 8'h00;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_BASE_LOW  = 8'hF0;
    localparam logic [7:0] MASK_IRQ_TYPE  = 8'h02;
    localparam logic [7:0] MASK_SELECTOR  = 8'h77;
    localparam logic [7:0] MASK_CFG_EVT   = 8'h7F;
    localparam logic [7:0] MASK_CFG_PLAIN = 8'h0F;
    localparam logic [7:0] MASK_CFG_LOCKD = 8'hF0;
    localparam int BIT_DEBOUNCE = 6;
    localparam int BIT_POLARITY = 5;
    localparam int BIT_EVT_TYPE = 4;
    localparam int BIT_LOCK     = 3;
    localparam int BIT_PULLUP   = 2;
    localparam int BIT_PUSHPULL = 1;
    localparam int BIT_OUT_EN   = 0;
    localparam int SEL_PORT_LSB = 4;
    localparam int NUM_PORTS    = 5;
    localparam int NUM_PINS     = 40;
    localparam logic [2:0] MAX_PORT = 3'd4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 40_000_000;
    localparam int DEBOUNCE_US     = 16;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int DB_W            = 10;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } gpc_bus_req_t;

    typedef struct packed {
        logic [7:0] out_val;
        logic [7:0] out_en_n;
        logic [7:0] pull_up;
    } gpc_port_drive_t;

    typedef enum logic [0:0] {GPC_PORT_EVENT, GPC_PORT_PLAIN} gpc_port_kind_t;

    function automatic gpc_port_kind_t port_kind(input logic [2:0] port);
        return (port == 3'd2 || port == 3'd3) ? GPC_PORT_PLAIN
                                               : GPC_PORT_EVENT;
    endfunction

endpackage

/* File: gpc_props.sv */
// Port checker for the GPIO configuration block
`timescale 1ns/1ps
module gpc_props (
    input wire logic        clk_sys,     // Clock
    input wire logic        rst,         // Reset
    input wire logic [7:0]  addr,        // Index
    input wire logic [7:0]  wdata,       // Write data
    input wire logic        wr,          // Write strobe
    input wire logic        rd,          // Read strobe
    input wire logic        unit_enable, // Global bit
    input wire logic [7:0]  rdata,       // Read data
    input wire logic [39:0] pin_out,     // Pin values
    input wire logic        unit_active  // Active flag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [7:0] sel_r;
    logic       plain;
    // Shadow of the selector, so window reads know the port
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            sel_r <= 8'h00;
        else if (wr && addr == 8'hF0)
            sel_r <= wdata;
    end
    assign plain = sel_r[6:4] == 3'd2 || sel_r[6:4] == 3'd3;
    a_dma_a_fixed: assert property (
        rd && addr == 8'h74 |=> rdata == 8'h04)
        else $error("dma report a wrong");
    a_dma_b_fixed: assert property (
        rd && addr == 8'h75 |=> rdata == 8'h04)
        else $error("dma report b wrong");
    a_base_low_align: assert property (
        rd && addr == 8'h61 |=> rdata[3:0] == 4'h0)
        else $error("base low bits set");
    a_irq_type_ro: assert property (
        rd && addr == 8'h71 |=> rdata[7:2] == 6'h00 && rdata[0])
        else $error("irq type fixed bits wrong");
    a_sel_resv_zero: assert property (
        rd && addr == 8'hF0 |=> !rdata[7] && !rdata[3])
        else $error("selector reserved bits set");
    a_plain_hi_zero: assert property (
        rd && addr == 8'hF1 && plain |=> rdata[7:4] == 4'h0)
        else $error("plain port high bits set");
    a_cfg_bit7_zero: assert property (
        rd && addr == 8'hF1 |=> !rdata[7])
        else $error("config bit 7 set");
    a_gpo_reset_low: assert property (
        $fell(rst) |-> pin_out[31:30] == 2'b00)
        else $error("port 3 outputs high in reset");
    a_active_gate: assert property (
        !unit_enable ##1 !unit_enable |=> !unit_active)
        else $error("active without global bit");
    c_window_rd: cover property (rd && addr == 8'hF1);
    c_plain_rd: cover property (rd && addr == 8'hF1 && plain);
    c_active: cover property (unit_active);
endmodule

bind gpc_top gpc_props i_gpc_props (.clk_sys(clk_sys), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .unit_enable(unit_enable), .rdata(rdata), .pin_out(pin_out),
    .unit_active(unit_active));

/* File: gpc_top.sv */
// GPIO pin configuration block: config registers, pin drive and events
//
// Notes on behaviour
// - Event ports four registers; ports 2,3 two
// - Ports 2,3 config bits 6-4 read zero
// - Port 3 pins 6,7 low during reset
// - Activate register resets to 00h
// - Base low bits 3-0 read zero
// - Interrupt type only bit 1 writable, 03h
// - Indexes 74h, 75h read 04h only
// - Selector bits 6-4 choose port 0-4
// - Selector bits 2-0 choose pin, reset 00h
// - Window F1h reaches selected pin config
// - Config resets 44h event, 04h plain
// - Bit 6 enables debounce of event input
// - Bit 5 selects event polarity
// - Bit 4 clear means edge events
// - Lock bit sticky, freezes drive settings
// - Bit 2 enables internal pull-up
// - Bit 1 selects push-pull over open-drain
// - Bit 0 enables output driver; pin 31 is never driven
`timescale 1ns/1ps
module gpc_top (
    input  wire logic        clk_sys,      // 40 MHz system clock
    input  wire logic        rst,          // Async reset, active high
    input  wire logic [7:0]  addr,         // Register index
    input  wire logic [7:0]  wdata,        // Write data
    input  wire logic        wr,           // Write strobe
    input  wire logic        rd,           // Read strobe
    input  wire logic        unit_enable,  // Global activation bit
    input  wire logic [39:0] pin_in,       // Pin levels, asynchronous
    output logic      [7:0]  rdata,        // Read data, cycle after rd
    output logic      [39:0] pin_out,      // Pin output value
    output logic      [39:0] pin_oe_n,     // Pin output enable, low drives
    output logic      [39:0] pin_pullup,   // Internal pull-up enable
    output logic             unit_active,  // Activate and global bit
    output logic             irq           // Level interrupt
);
    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    gpc_pkg::gpc_bus_req_t req;
    logic [7:0] act_r,  act_nxt;
    logic [7:0] bhi_r,  bhi_nxt;
    logic [7:0] blo_r,  blo_nxt;
    logic [7:0] inum_r, inum_nxt;
    logic [7:0] ityp_r, ityp_nxt;
    logic [7:0] sel_r,  sel_nxt;
    logic [7:0] dout_r [gpc_pkg::NUM_PORTS];
    logic [7:0] dout_nxt [gpc_pkg::NUM_PORTS];
    logic [7:0] even_r [gpc_pkg::NUM_PORTS];
    logic [7:0] even_nxt [gpc_pkg::NUM_PORTS];
    logic [7:0] evst_r [gpc_pkg::NUM_PORTS];
    logic [7:0] evst_nxt [gpc_pkg::NUM_PORTS];
    logic [4:0] ist_r,  ist_nxt;
    logic [4:0] imsk_r, imsk_nxt;

    logic [2:0] sel_port;
    logic [5:0] sel_pin;
    logic       sel_ok;
    logic [7:0] win_wdata;
    logic       win_we;
    logic [7:0] cfg_rdata;
    logic [319:0] all_cfg;
    logic       rd_win_r;
    logic [7:0] rd_other_r, rd_other_nxt;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    assign sel_port = sel_r[6:4];
    assign sel_pin  = {sel_port, sel_r[2:0]};
    assign sel_ok   = sel_port <= gpc_pkg::MAX_PORT;

    // Runtime offset decode
    function automatic logic run_hit(input logic [7:0] a);
        return a[7:4] == gpc_pkg::IDX_RUN_BASE[7:4];
    endfunction

    // Offset to port and register slot (0 out, 1 in, 2 enable, 3 status)
    function automatic logic [4:0] run_map(input logic [3:0] o);
        logic [4:0] r;
        r = {1'b0, o[3:2], o[1:0]};
        if (o >= 4'h8 && o < 4'hC) begin
            r = {o[3:1] - 3'd2, 1'b0, o[0]};
        end else if (o >= 4'hC) begin
            r = {3'd4, o[1:0]};
        end
        return r;
    endfunction

    logic [7:0] din_s1_r [gpc_pkg::NUM_PORTS];
    logic [7:0] din_r    [gpc_pkg::NUM_PORTS];

    // ------------------------------------------------------------
    // Window write data: masks, lock stickiness
    // ------------------------------------------------------------
    logic [7:0] cur_cfg;
    assign cur_cfg = all_cfg[sel_pin*8 +: 8];

    always_comb begin
        logic [7:0] m;
        m = 8'h00;
        m = (gpc_pkg::port_kind(sel_port) == gpc_pkg::GPC_PORT_PLAIN)
            ? gpc_pkg::MASK_CFG_PLAIN : gpc_pkg::MASK_CFG_EVT;
        win_wdata = req.wdata & m;
        if (cur_cfg[gpc_pkg::BIT_LOCK]) begin
            // Locked pins keep drive fields; lock cannot be cleared
            win_wdata = (win_wdata & gpc_pkg::MASK_CFG_LOCKD)
                      | (cur_cfg & ~gpc_pkg::MASK_CFG_LOCKD);
        end
        win_we = req.wr && req.addr == gpc_pkg::IDX_PIN_CONFIG_WIN
                 && sel_ok;
    end

    gpc_cfg_mem u_mem (
        .clk_sys (clk_sys),
        .rst     (rst),
        .waddr   (sel_pin),
        .wdata   (win_wdata),
        .we      (win_we),
        .raddr   (sel_pin),
        .rdata   (cfg_rdata),
        .all_cfg (all_cfg)
    );

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    logic [39:0] db_r, db_nxt;
    logic [39:0] prev_r;
    logic [gpc_pkg::DB_W-1:0] dbc_r [40];
    logic [gpc_pkg::DB_W-1:0] dbc_nxt [40];
    logic [39:0] hit;

    always_comb begin
        for (int i = 0; i < 40; i++) begin
            logic [7:0] c;
            logic       raw, act;
            c = all_cfg[i*8 +: 8];
            raw = din_r[i/8][i%8];
            dbc_nxt[i] = dbc_r[i];
            db_nxt[i]  = db_r[i];
            if (!c[gpc_pkg::BIT_DEBOUNCE]) begin
                db_nxt[i]  = raw;
                dbc_nxt[i] = '0;
            end else if (raw == db_r[i]) begin
                dbc_nxt[i] = '0;
            end else if (dbc_r[i] ==
                         gpc_pkg::DB_W'(gpc_pkg::DEBOUNCE_CYCLES - 1)) begin
                db_nxt[i]  = raw;
                dbc_nxt[i] = '0;
            end else begin
                dbc_nxt[i] = dbc_r[i] + 1'b1;
            end
            act = c[gpc_pkg::BIT_POLARITY] ? db_r[i] : ~db_r[i];
            if (c[gpc_pkg::BIT_EVT_TYPE]) begin
                hit[i] = act;
            end else begin
                hit[i] = act && (db_r[i] != prev_r[i]);
            end
            if (gpc_pkg::port_kind(3'(i/8)) == gpc_pkg::GPC_PORT_PLAIN) begin
                hit[i] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Register writes and status
    // ------------------------------------------------------------
    always_comb begin
        logic [4:0] rm;
        logic       rhit;
        rm   = run_map(req.addr[3:0]);
        rhit = req.wr && run_hit(req.addr);
        act_nxt  = act_r;
        bhi_nxt  = bhi_r;
        blo_nxt  = blo_r;
        inum_nxt = inum_r;
        ityp_nxt = ityp_r;
        sel_nxt  = sel_r;
        imsk_nxt = imsk_r;
        ist_nxt  = ist_r;
        for (int p = 0; p < gpc_pkg::NUM_PORTS; p++) begin
            dout_nxt[p] = dout_r[p];
            even_nxt[p] = even_r[p];
            evst_nxt[p] = evst_r[p];
        end
        if (req.wr) begin
            case (req.addr)
                gpc_pkg::IDX_UNIT_ACTIVATE: act_nxt = req.wdata;
                gpc_pkg::IDX_BASE_HIGH:     bhi_nxt = req.wdata;
                gpc_pkg::IDX_BASE_LOW:
                    blo_nxt = req.wdata & gpc_pkg::MASK_BASE_LOW;
                gpc_pkg::IDX_IRQ_NUMBER:    inum_nxt = req.wdata;
                gpc_pkg::IDX_IRQ_TYPE:
                    ityp_nxt = (ityp_r & ~gpc_pkg::MASK_IRQ_TYPE)
                             | (req.wdata & gpc_pkg::MASK_IRQ_TYPE);
                gpc_pkg::IDX_PIN_SELECTOR:
                    sel_nxt = req.wdata & gpc_pkg::MASK_SELECTOR;
                gpc_pkg::IDX_EVT_MASK:      imsk_nxt = req.wdata[4:0];
                gpc_pkg::IDX_EVT_STATUS:
                    ist_nxt = ist_r & ~req.wdata[4:0];
                default: ;
            endcase
        end
        for (int p = 0; p < gpc_pkg::NUM_PORTS; p++) begin
            logic [7:0] lk;
            for (int b = 0; b < 8; b++) begin
                lk[b] = all_cfg[(p*8+b)*8 + gpc_pkg::BIT_LOCK];
            end
            if (rhit && rm[4:2] == 3'(p)) begin
                if (rm[1:0] == 2'd0) begin
                    dout_nxt[p] = (dout_r[p] & lk)
                                | (req.wdata & ~lk);
                end
                if (gpc_pkg::port_kind(3'(p)) == gpc_pkg::GPC_PORT_EVENT) begin
                    if (rm[1:0] == 2'd2) even_nxt[p] = req.wdata;
                    if (rm[1:0] == 2'd3) begin
                        evst_nxt[p] = evst_r[p] & ~req.wdata;
                    end
                end
            end
            // Set wins over a same-cycle clear
            evst_nxt[p] = evst_nxt[p] | (hit[p*8 +: 8] & even_r[p]);
            if (|(hit[p*8 +: 8] & even_r[p])) begin
                ist_nxt[p] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Read mux (non-window reads registered here)
    // ------------------------------------------------------------
    always_comb begin
        logic [4:0] rm;
        rm = run_map(req.addr[3:0]);
        rd_other_nxt = 8'h00;
        case (req.addr)
            gpc_pkg::IDX_UNIT_ACTIVATE: rd_other_nxt = act_r;
            gpc_pkg::IDX_BASE_HIGH:     rd_other_nxt = bhi_r;
            gpc_pkg::IDX_BASE_LOW:      rd_other_nxt = blo_r;
            gpc_pkg::IDX_IRQ_NUMBER:    rd_other_nxt = inum_r;
            gpc_pkg::IDX_IRQ_TYPE:      rd_other_nxt = ityp_r;
            gpc_pkg::IDX_DMA_REPORT_A,
            gpc_pkg::IDX_DMA_REPORT_B:
                rd_other_nxt = gpc_pkg::VAL_NO_DMA;
            gpc_pkg::IDX_PIN_SELECTOR:  rd_other_nxt = sel_r;
            gpc_pkg::IDX_EVT_STATUS:    rd_other_nxt = {3'b000, ist_r};
            gpc_pkg::IDX_EVT_MASK:      rd_other_nxt = {3'b000, imsk_r};
            default: begin
                if (run_hit(req.addr)) begin
                    case (rm[1:0])
                        2'd0: rd_other_nxt = dout_r[rm[4:2]];
                        2'd1: rd_other_nxt = din_r[rm[4:2]];
                        2'd2: rd_other_nxt = even_r[rm[4:2]];
                        default: rd_other_nxt = evst_r[rm[4:2]];
                    endcase
                end
            end
        endcase
    end

    // Config memory answers one cycle later, so the window read
    // picks the memory's registered output instead of a local copy.
    always_comb begin
        rdata = rd_win_r ? cfg_rdata : rd_other_r;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            act_r  <= gpc_pkg::RST_ACTIVATE;
            bhi_r  <= gpc_pkg::RST_BASE;
            blo_r  <= gpc_pkg::RST_BASE;
            inum_r <= gpc_pkg::RST_IRQ_NUM;
            ityp_r <= gpc_pkg::RST_IRQ_TYPE;
            sel_r  <= gpc_pkg::RST_SELECTOR;
            ist_r  <= '0;
            imsk_r <= '0;
            rd_win_r   <= 1'b0;
            rd_other_r <= 8'h00;
            db_r   <= '1;
            prev_r <= '1;
            for (int p = 0; p < gpc_pkg::NUM_PORTS; p++) begin
                dout_r[p]   <= gpc_pkg::RST_DATA;
                even_r[p]   <= gpc_pkg::RST_DATA;
                evst_r[p]   <= gpc_pkg::RST_DATA;
                // Idle pad level, so no false edge follows reset
                din_s1_r[p] <= 8'hFF;
                din_r[p]    <= 8'hFF;
            end
            for (int i = 0; i < 40; i++) begin
                dbc_r[i] <= '0;
            end
        end else begin
            act_r  <= act_nxt;
            bhi_r  <= bhi_nxt;
            blo_r  <= blo_nxt;
            inum_r <= inum_nxt;
            ityp_r <= ityp_nxt;
            sel_r  <= sel_nxt;
            ist_r  <= ist_nxt;
            imsk_r <= imsk_nxt;
            rd_win_r   <= req.rd && req.addr == gpc_pkg::IDX_PIN_CONFIG_WIN;
            rd_other_r <= req.rd ? rd_other_nxt : 8'h00;
            db_r   <= db_nxt;
            prev_r <= db_r;
            for (int p = 0; p < gpc_pkg::NUM_PORTS; p++) begin
                dout_r[p]   <= dout_nxt[p];
                even_r[p]   <= even_nxt[p];
                evst_r[p]   <= evst_nxt[p];
                din_s1_r[p] <= pin_in[p*8 +: 8];
                din_r[p]    <= din_s1_r[p];
            end
            for (int i = 0; i < 40; i++) begin
                dbc_r[i] <= dbc_nxt[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drive, all outputs from flops
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_out     <= '0;
            pin_oe_n    <= '1;
            pin_pullup  <= '1;
            unit_active <= 1'b0;
            irq         <= 1'b0;
        end else begin
            for (int i = 0; i < 40; i++) begin
                logic [7:0] c;
                c = all_cfg[i*8 +: 8];
                pin_pullup[i] <= c[gpc_pkg::BIT_PULLUP];
                // Open-drain drives only a low
                pin_oe_n[i] <= ~(c[gpc_pkg::BIT_OUT_EN] &&
                    (c[gpc_pkg::BIT_PUSHPULL] || !dout_r[i/8][i%8]));
                pin_out[i] <= dout_r[i/8][i%8];
            end
            pin_oe_n[31] <= 1'b1;
            pin_out[31]  <= 1'b0;
            unit_active <= act_r[0] && unit_enable;
            irq         <= |(ist_nxt & imsk_r);
        end
    end
endmodule

/* File: tb.sv */
// Self-checking bench for the GPIO configuration block
`timescale 1ns/1ps
module tb;
    logic        clk_sys, rst, wr, rd, unit_enable, unit_active, irq;
    logic [7:0]  addr, wdata, rdata;
    logic [39:0] pin_in, pin_out, pin_oe_n, pin_pullup, ext_drv, ext_en;
    int          n_mismatch = 0;
    int          checks = 0;
    int          cyc = 0;
    gpc_top i_gpc_top (.clk_sys(clk_sys), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .unit_enable(unit_enable),
        .pin_in(pin_in), .rdata(rdata), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
        .unit_active(unit_active), .irq(irq));
    gpc_pin_env i_gpc_pin_env (.clk_sys(clk_sys), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .ext_drv(ext_drv),
        .ext_en(ext_en), .pin_in(pin_in));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic print_verdict();
        $display("TB: mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Whole run is under 2000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic pins(input int n, input logic [7:0] e);
        repeat (n) @(posedge clk_sys);
        #1 chk({5'h0, pin_out[2], pin_oe_n[2], pin_pullup[2]}, e);
    endtask
    initial begin
        {rst, wr, rd, addr, wdata, unit_enable} = {1'b1, 19'h0};
        ext_drv = 40'h1;
        ext_en  = 40'h1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd_reg(8'h30, 8'h00);
        rd_reg(8'h60, 8'h00);
        rd_reg(8'h71, 8'h03);
        rd_reg(8'h74, 8'h04);
        rd_reg(8'hF0, 8'h00);
        for (int p = 0; p < 5; p++) begin
            wr_reg(8'hF0, {1'b0, p[2:0], 4'h4});
            rd_reg(8'hF1, (p == 2 || p == 3) ? 8'h04 : 8'h44);
        end
        wr_reg(8'h61, 8'hFF);
        rd_reg(8'h61, 8'hF0);
        wr_reg(8'h71, 8'h00);
        rd_reg(8'h71, 8'h01);
        wr_reg(8'h75, 8'h00);
        rd_reg(8'h75, 8'h04);
        rd_reg(8'h50, 8'h00);
        wr_reg(8'hF0, 8'hFF);
        rd_reg(8'hF0, 8'h77);
        wr_reg(8'h30, 8'h01);
        unit_enable <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 chk({7'h0, unit_active}, 8'h01);
        wr_reg(8'hF0, 8'h21);
        wr_reg(8'hF1, 8'hFF);
        rd_reg(8'hF1, 8'h0F);
        wr_reg(8'hF1, 8'h00);
        rd_reg(8'hF1, 8'h0F);
        wr_reg(8'hF0, 8'h02);
        wr_reg(8'hF1, 8'h03);
        wr_reg(8'h80, 8'h04);
        pins(2, 8'h04);
        wr_reg(8'hF1, 8'h05);
        pins(2, 8'h07);
        wr_reg(8'h80, 8'h00);
        pins(2, 8'h01);
        rd_reg(8'h89, 8'hFD);
        // Pin 0 events, no debounce first
        wr_reg(8'h82, 8'h01);
        wr_reg(8'hE1, 8'h01);
        wr_reg(8'hF0, 8'h00);
        wr_reg(8'hF1, 8'h04);
        ext_drv <= 40'h0;
        repeat (10) @(posedge clk_sys);
        rd_reg(8'h83, 8'h01);
        chk({7'h0, irq}, 8'h01);
        wr_reg(8'h83, 8'h01);
        wr_reg(8'hE0, 8'h01);
        rd_reg(8'h83, 8'h00);
        wr_reg(8'hF1, 8'h24);
        ext_drv <= 40'h1;
        repeat (10) @(posedge clk_sys);
        rd_reg(8'h83, 8'h01);
        wr_reg(8'h83, 8'h01);
        wr_reg(8'hF1, 8'h14);
        ext_drv <= 40'h0;
        repeat (10) @(posedge clk_sys);
        wr_reg(8'h83, 8'h01);
        rd_reg(8'h83, 8'h01);
        ext_drv <= 40'h1;
        repeat (10) @(posedge clk_sys);
        wr_reg(8'h83, 8'h01);
        rd_reg(8'h83, 8'h00);
        // Short glitch is filtered, long low passes
        wr_reg(8'hF1, 8'h44);
        ext_drv <= 40'h0;
        repeat (100) @(posedge clk_sys);
        ext_drv <= 40'h1;
        repeat (20) @(posedge clk_sys);
        rd_reg(8'h83, 8'h00);
        ext_drv <= 40'h0;
        repeat (700) @(posedge clk_sys);
        rd_reg(8'h83, 8'h01);
        wr_reg(8'h8A, 8'hC0);
        repeat (2) @(posedge clk_sys);
        #1 chk({7'h0, pin_out[30]}, 8'h01);
        @(posedge clk_sys);
        rst <= 1'b1;
        #1 chk({6'h0, pin_out[31:30]}, 8'h00);
        print_verdict();
    end
endmodule
